// ### rtl/sbo_pkg.sv
// Purpose: Shared constants and types for the mode register and burst order block
// Assumes: One beat per clock, 8-bit data lane, same-clock command pins
// Notes: Field positions follow the address pins of the mode-register-set command
package sbo_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // Command pin codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    // Bank codes selecting a mode register
    localparam logic [2:0] BANK_MODE_ZERO = 3'h0;
    localparam logic [2:0] BANK_MODE_THREE = 3'h3;
    // Mode register three fields
    localparam int SRC_SEL_LSB = 0;
    localparam int READOUT_EN_BIT = 2;
    localparam logic [1:0] SRC_PATTERN = 2'h0;
    localparam logic [1:0] SRC_THERMAL = 2'h3;
    localparam logic [1:0] SRC_SEL_RST = 2'h0;
    localparam logic READOUT_EN_RST = 1'b0;
    // Mode register zero fields
    localparam int BURST_LEN_LSB = 0;
    localparam int BURST_TYPE_BIT = 3;
    localparam logic [1:0] BL_BURST_OF_EIGHT = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
    localparam logic [1:0] BL_FIXED_CHOP_FOUR = 2'h2;
    localparam logic [1:0] BURST_LEN_RST = 2'h0;
    localparam logic BURST_TYPE_RST = 1'b0;
    // Command address bit that picks chop on the fly, low = chop
    localparam int CHOP_SEL_BIT = 12;
    // Burst geometry
    localparam logic [2:0] LAST_BEAT = 3'h7;
    localparam logic [2:0] HALF_BEAT = 3'h4;
    // Readout pattern per beat
    localparam logic [7:0] PATTERN_EVEN = 8'h00;
    localparam logic [7:0] PATTERN_ODD = 8'hFF;
    localparam logic [7:0] RESERVED_DATA = 8'h00;
    // Internal write start, in clocks from the write command
    localparam logic [3:0] WR_START_EIGHT_CYC = 4'h8;
    localparam logic [3:0] WR_PULL_IN_CYC = 4'h2;
    localparam logic [3:0] WR_START_CHOP_CYC = WR_START_EIGHT_CYC - WR_PULL_IN_CYC;

    typedef enum logic [2:0] {
        SBO_IDLE = 3'b001,
        SBO_READ = 3'b010,
        SBO_WRITE = 3'b100
    } sbo_state_t;
endpackage

// ### rtl/sbo_beat_order.sv
// Purpose: Maps a burst start position and beat number to a column index
// Assumes: Purely combinational, eight-beat bursts
// Notes: Shared by the read and write sequencers
`timescale 1ns/1ps
`default_nettype none
module sbo_beat_order (
    input wire logic [2:0] start, // Burst start position
    input wire logic [2:0] beat, // Beat number within burst
    input wire logic interleave, // High for interleaved order
    output logic [2:0] col // Column index delivered at this beat
);
    import sbo_pkg::*;

    always_comb begin
        if (interleave) begin
            col = start ^ beat;
        end else begin
            col = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
        end
    end
endmodule
`default_nettype wire

// ### rtl/sbo_mode_burst.sv
// Purpose: Mode register three decode and in-burst beat ordering for reads and writes
// Assumes: Command pins come from logic on clk; one beat per clock
// Notes: A read or write command arriving while a burst runs is ignored
// Notes: Burst length code 11 is reserved and runs as eight beats
//
// Contract
// - MRS with bank 011 writes register three
// - Low address bits choose readout source
// - Address bit 2 enables readout instead array
// - Source select ignored while readout disabled
// - Burst type bit picks interleaved or nibble
// - Read start taken from low column bits
// - Eight-beat writes fixed order, ignore low bits
// - Chopped write: CA2 picks half, rest ignored
// - Interleaved read index is start XOR beat
// - Nibble read: bit2 XOR, low bits add
// - Chopped read tristates last four slots
// - Fixed chop pulls internal write two earlier
// - On-the-fly chop keeps eight-beat write timing
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sbo_mode_burst (
    input wire logic clk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic cs_n, // Chip select
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write enable
    input wire logic [2:0] ba, // Bank address
    input wire logic [sbo_pkg::ADDR_W-1:0] addr, // Address pins
    input wire logic [sbo_pkg::DATA_W-1:0] dq_in, // Write data beat
    input wire logic [sbo_pkg::DATA_W-1:0] array_rdata, // Array data for array_col
    input wire logic [sbo_pkg::DATA_W-1:0] thermal_code, // Thermal sensor value
    output logic array_rd, // Array read strobe for this beat
    output logic [2:0] array_col, // Column index requested from array
    output logic [sbo_pkg::DATA_W-1:0] dq_out, // Read data beat
    output logic dq_oe, // Data driver enable
    output logic dqs_out, // Read strobe level
    output logic dqs_oe, // Strobe driver enable
    output logic wr_en, // Write beat into array
    output logic [2:0] wr_col, // Column of the write beat
    output logic [sbo_pkg::DATA_W-1:0] wr_data, // Data of the write beat
    output logic int_write_start, // Internal write start pulse
    output logic readout_active, // Reads come from readout source
    output logic [1:0] readout_source // Effective source code
);
    import sbo_pkg::*;

    logic [3:0] cmd;
    logic mrs_three, mrs_zero, rd_cmd, wr_cmd, chop_now;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign mrs_three = (cmd == CMD_MRS) && (ba == BANK_MODE_THREE);
    assign mrs_zero = (cmd == CMD_MRS) && (ba == BANK_MODE_ZERO);
    assign rd_cmd = (cmd == CMD_READ);
    assign wr_cmd = (cmd == CMD_WRITE);

    // Mode registers
    logic readout_en_q, readout_en_d;
    logic [1:0] src_sel_q, src_sel_d;
    logic burst_type_q, burst_type_d;
    logic [1:0] burst_len_q, burst_len_d;

    always_comb begin
        readout_en_d = readout_en_q;
        src_sel_d = src_sel_q;
        burst_type_d = burst_type_q;
        burst_len_d = burst_len_q;
        if (mrs_three) begin
            // Upper bits are expected zero and are not stored
            readout_en_d = addr[READOUT_EN_BIT];
            src_sel_d = addr[SRC_SEL_LSB +: 2];
        end
        if (mrs_zero) begin
            burst_type_d = addr[BURST_TYPE_BIT];
            burst_len_d = addr[BURST_LEN_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readout_en_q <= READOUT_EN_RST;
            src_sel_q <= SRC_SEL_RST;
            burst_type_q <= BURST_TYPE_RST;
            burst_len_q <= BURST_LEN_RST;
        end else begin
            readout_en_q <= readout_en_d;
            src_sel_q <= src_sel_d;
            burst_type_q <= burst_type_d;
            burst_len_q <= burst_len_d;
        end
    end

    assign readout_active = readout_en_q;
    // Selection is masked so a stale code never leaks out while disabled
    always_comb begin
        readout_source = SRC_PATTERN;
        if (readout_en_q) begin
            readout_source = src_sel_q;
        end
    end

    logic fixed_chop, otf_chop;
    assign fixed_chop = (burst_len_q == BL_FIXED_CHOP_FOUR);
    // On-the-fly chop is asked for by a low chop bit beside the command
    assign otf_chop = (burst_len_q == BL_ON_THE_FLY) && !addr[CHOP_SEL_BIT];
    assign chop_now = fixed_chop || otf_chop;

    // Burst sequencer
    sbo_state_t st_q, st_d;
    logic [2:0] beat_q, beat_d;
    logic [2:0] start_q, start_d;
    logic chop_q, chop_d;

    always_comb begin
        st_d = st_q;
        beat_d = beat_q;
        start_d = start_q;
        chop_d = chop_q;
        case (st_q)
            SBO_IDLE: begin
                beat_d = 3'h0;
                // Only an idle sequencer takes bursts; the controller keeps the spacing
                if (rd_cmd) begin
                    st_d = SBO_READ;
                    start_d = addr[2:0];
                    chop_d = chop_now;
                end else if (wr_cmd) begin
                    st_d = SBO_WRITE;
                    chop_d = chop_now;
                    // Write order is fixed; chop keeps only the half select
                    start_d = chop_now ? {addr[2], 2'h0} : 3'h0;
                end
            end
            SBO_READ, SBO_WRITE: begin
                beat_d = 3'(beat_q + 3'h1);
                if (beat_q == LAST_BEAT) begin
                    st_d = SBO_IDLE;
                end
            end
            default: begin
                st_d = SBO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= SBO_IDLE;
            beat_q <= 3'h0;
            start_q <= 3'h0;
            chop_q <= 1'b0;
        end else begin
            st_q <= st_d;
            beat_q <= beat_d;
            start_q <= start_d;
            chop_q <= chop_d;
        end
    end

    logic [2:0] cur_col;
    sbo_beat_order sbo_beat_order_inst (
        .start(start_q),
        .beat(beat_q),
        .interleave(burst_type_q),
        .col(cur_col)
    );

    // Slots 4..7 of a chopped burst carry nothing
    logic beat_live;
    assign beat_live = !chop_q || (beat_q < HALF_BEAT);

    // Read pipeline: stage one asks the array, stage two drives the pins
    logic rd_live_q, rd_live_d;
    logic rd_slot_q, rd_slot_d;
    logic [2:0] col_q, col_d;
    logic odd_q, odd_d;
    logic [DATA_W-1:0] dq_q, dq_d;
    logic dq_oe_q, dq_oe_d;
    logic dqs_q, dqs_d;
    logic dqs_oe_q, dqs_oe_d;

    always_comb begin
        rd_slot_d = (st_q == SBO_READ);
        rd_live_d = (st_q == SBO_READ) && beat_live;
        col_d = col_q;
        if (st_q == SBO_READ) begin
            col_d = cur_col;
        end
        odd_d = beat_q[0];
        dq_oe_d = rd_live_q;
        dqs_oe_d = rd_live_q;
        // Strobe is a level per beat: high on even beats, low on odd
        dqs_d = rd_live_q && !odd_q;
        dq_d = dq_q;
        if (rd_live_q) begin
            if (!readout_en_q) begin
                dq_d = array_rdata;
            end else begin
                case (src_sel_q)
                    SRC_PATTERN: begin
                        // Alternating beats let the capture side train on a known edge
                        dq_d = odd_q ? PATTERN_ODD : PATTERN_EVEN;
                    end
                    SRC_THERMAL: begin
                        dq_d = thermal_code;
                    end
                    default: begin
                        dq_d = RESERVED_DATA;
                    end
                endcase
            end
        end else if (rd_slot_q) begin
            dq_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_live_q <= 1'b0;
            rd_slot_q <= 1'b0;
            col_q <= 3'h0;
            odd_q <= 1'b0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            dqs_q <= 1'b0;
            dqs_oe_q <= 1'b0;
        end else begin
            rd_live_q <= rd_live_d;
            rd_slot_q <= rd_slot_d;
            col_q <= col_d;
            odd_q <= odd_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            dqs_q <= dqs_d;
            dqs_oe_q <= dqs_oe_d;
        end
    end

    // Array is not touched when the readout replaces it
    assign array_rd = rd_live_q && !readout_en_q;
    assign array_col = col_q;
    assign dq_out = dq_q;
    assign dq_oe = dq_oe_q;
    assign dqs_out = dqs_q;
    assign dqs_oe = dqs_oe_q;

    // Write beats and internal write start
    logic wr_en_q, wr_en_d;
    logic [2:0] wr_col_q, wr_col_d;
    logic [DATA_W-1:0] wr_data_q, wr_data_d;
    logic [3:0] wdly_q, wdly_d;
    logic wstart_q, wstart_d;

    always_comb begin
        wr_en_d = 1'b0;
        wr_col_d = wr_col_q;
        wr_data_d = wr_data_q;
        if (st_q == SBO_WRITE) begin
            // Chopped slots 4..7 raise no strobe; their data lane is a don't-care
            wr_en_d = beat_live;
            wr_col_d = cur_col;
            wr_data_d = dq_in;
        end
        wstart_d = (wdly_q == 4'h1);
        wdly_d = 4'h0;
        if (wdly_q != 4'h0) begin
            wdly_d = 4'(wdly_q - 4'h1);
        end
        if ((st_q == SBO_IDLE) && !rd_cmd && wr_cmd) begin
            // Only a chop fixed in the mode register pulls the start in
            wdly_d = fixed_chop ? WR_START_CHOP_CYC : WR_START_EIGHT_CYC;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_en_q <= 1'b0;
            wr_col_q <= 3'h0;
            wr_data_q <= '0;
            wdly_q <= 4'h0;
            wstart_q <= 1'b0;
        end else begin
            wr_en_q <= wr_en_d;
            wr_col_q <= wr_col_d;
            wr_data_q <= wr_data_d;
            wdly_q <= wdly_d;
            wstart_q <= wstart_d;
        end
    end

    assign wr_en = wr_en_q;
    assign wr_col = wr_col_q;
    assign wr_data = wr_data_q;
    assign int_write_start = wstart_q;
endmodule
`default_nettype wire

// ### test/sbo_mb_assertions.sv
// Purpose: Port checks for mode register three and burst order
// Assumes: Register zero is shadowed here from the command traffic
// Notes: Delays count edges from the edge that takes the command
`timescale 1ns/1ps
`default_nettype none
module sbo_mb_assertions (
    input wire logic clk, // Clock
    input wire logic rst_n, // Sync reset
    input wire logic cs_n, // Chip select
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write enable
    input wire logic [2:0] ba, // Bank
    input wire logic [sbo_pkg::ADDR_W-1:0] addr, // Address
    input wire logic array_rd, // Array read
    input wire logic [2:0] array_col, // Array column
    input wire logic dq_oe, // Data enable
    input wire logic dqs_oe, // Strobe enable
    input wire logic wr_en, // Write beat
    input wire logic [2:0] wr_col, // Write column
    input wire logic int_write_start, // Write start
    input wire logic readout_active, // Readout on
    input wire logic [1:0] readout_source // Source
);
    import sbo_pkg::*;
    logic [3:0] cmd, busy_q;
    logic [2:0] mr0_q;
    logic mrs3, rd_acc, wr_acc, chop, fixed;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign mrs3 = cmd == CMD_MRS && ba == BANK_MODE_THREE;
    assign rd_acc = busy_q == 4'h0 && cmd == CMD_READ;
    assign wr_acc = busy_q == 4'h0 && cmd == CMD_WRITE;
    assign fixed = mr0_q[1:0] == BL_FIXED_CHOP_FOUR;
    // Commands inside a running burst are dropped, so track the busy span
    assign chop = fixed || (mr0_q[1:0] == BL_ON_THE_FLY && !addr[CHOP_SEL_BIT]);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 4'h0;
            mr0_q <= 3'h0;
        end else begin
            if (rd_acc || wr_acc) begin
                busy_q <= 4'h8;
            end else if (busy_q != 4'h0) begin
                busy_q <= busy_q - 4'h1;
            end
            if (cmd == CMD_MRS && ba == BANK_MODE_ZERO) begin
                mr0_q <= {addr[BURST_TYPE_BIT], addr[1:0]};
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence tail_quiet;
        (!dq_oe && !dqs_oe) [*4];
    endsequence
    chk_mrs_enable: assert property (mrs3 |=> readout_active == $past(addr[2]))
        else $error("readout enable not loaded");
    chk_src_load: assert property (mrs3 && addr[2] |=> readout_source == $past(addr[1:0]))
        else $error("readout source not loaded");
    chk_src_ignored: assert property (!readout_active |-> readout_source == 2'h0)
        else $error("source shown while readout off");
    chk_reg_hold: assert property (!mrs3 |=> $stable(readout_active) && $stable(readout_source))
        else $error("register three changed without write");
    chk_read_start: assert property (rd_acc && !readout_active |-> ##2 array_rd && array_col == $past(addr[2:0], 2))
        else $error("read start column wrong");
    chk_ilv_order: assert property (rd_acc && !readout_active && !chop && mr0_q[2] |-> ##8 array_col == ($past(addr[2:0], 8) ^ 3'h6))
        else $error("interleaved beat column wrong");
    chk_nib_order: assert property (rd_acc && !readout_active && !chop && !mr0_q[2] |-> ##7 array_col == {$past(addr[2], 7) ^ 1'b1, $past(addr[1:0], 7) + 2'h1})
        else $error("nibble beat column wrong");
    chk_chop_tail: assert property (rd_acc && chop |-> ##7 tail_quiet)
        else $error("drivers on in chopped slots");
    chk_wr_eight: assert property (wr_acc && !chop |-> ##2 wr_en && wr_col == 3'h0)
        else $error("eight-beat write not from zero");
    chk_wr_chop: assert property (wr_acc && chop |-> ##2 wr_en && wr_col == {$past(addr[2], 2), 2'h0})
        else $error("chopped write half wrong");
    chk_start_full: assert property (wr_acc && !fixed |-> ##9 int_write_start)
        else $error("write start not at eight-beat time");
    chk_start_fixed: assert property (wr_acc && fixed |-> ##7 int_write_start)
        else $error("fixed chop write start not pulled in");
endmodule
bind sbo_mode_burst sbo_mb_assertions sbo_mb_assertions_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .array_rd(array_rd), .array_col(array_col), .dq_oe(dq_oe),
    .dqs_oe(dqs_oe), .wr_en(wr_en), .wr_col(wr_col), .int_write_start(int_write_start),
    .readout_active(readout_active), .readout_source(readout_source));
`default_nettype wire

// ### test/sbo_ctrl_model.sv
// Purpose: Memory controller model driving the command pins
// Assumes: One command at a time, issued from the bench
// Notes: Released command pins go high; bank, address and data carry inverted values, never the last ones
`timescale 1ns/1ps
`default_nettype none
module sbo_ctrl_model (
    input wire logic clk, // Clock
    output logic cs_n, // Chip select
    output logic ras_n, // Row strobe
    output logic cas_n, // Column strobe
    output logic we_n, // Write enable
    output logic [2:0] ba, // Bank
    output logic [sbo_pkg::ADDR_W-1:0] addr, // Address
    output logic [sbo_pkg::DATA_W-1:0] dq_in // Write data
);
    import sbo_pkg::*;
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = 3'h0;
        addr = 15'h0000;
        dq_in = 8'h00;
    end
    // Returns at the edge that samples the command
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        ba <= ~b;
        addr <= ~a;
    endtask
    task automatic set_mode(input logic [2:0] b, input logic [3:0] f);
        issue(CMD_MRS, b, {11'h000, f});
    endtask
    task automatic write_data(input logic [7:0] base);
        dq_in <= base;
        for (int i = 1; i < 8; i++) begin
            @(posedge clk);
            dq_in <= base + 8'(i);
        end
        @(posedge clk);
        dq_in <= ~dq_in;
    endtask
endmodule
`default_nettype wire

// ### test/sbo_mode_burst_tb.sv
// Purpose: Self-checking bench for mode register three and burst order
// Assumes: Array answers with a value built from the requested column
// Notes: Outputs are sampled 1 ns after each edge
`timescale 1ns/1ps
`default_nettype none
module sbo_mode_burst_tb;
    import sbo_pkg::*;
    localparam logic [7:0] THERM = 8'h5C;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, ras_n, cas_n, we_n, array_rd, dq_oe, dqs_out, dqs_oe, wr_en, int_write_start, readout_active;
    logic [2:0] ba, array_col, wr_col;
    logic [1:0] readout_source;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_in, array_rdata, dq_out, wr_data;
    int n_errors = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    assign array_rdata = {5'h14, array_col};
    sbo_ctrl_model sbo_ctrl_model_inst (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .dq_in(dq_in));
    sbo_mode_burst sbo_mode_burst_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .array_rdata(array_rdata), .thermal_code(THERM),
        .array_rd(array_rd), .array_col(array_col), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
        .dqs_oe(dqs_oe), .wr_en(wr_en), .wr_col(wr_col), .wr_data(wr_data), .int_write_start(int_write_start),
        .readout_active(readout_active), .readout_source(readout_source));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] j, input logic ilv);
        return ilv ? s ^ j : {s[2] ^ j[2], s[1:0] + j[1:0]};
    endfunction
    // m is {readout on, source}
    task automatic run_read(input logic [2:0] s, input logic ilv, input logic ch, input logic [2:0] m,
                            input logic a12);
        int j;
        logic [2:0] c;
        sbo_ctrl_model_inst.issue(CMD_READ, 3'h0, {2'h0, a12, 9'h000, s});
        for (int k = 1; k <= 11; k++) begin
            @(posedge clk);
            #1;
            j = k - 1;
            c = col_of(s, 3'(j), ilv);
            if (j >= 0 && j < (ch ? 4 : 8)) begin
                chk(array_rd, !m[2]);
                if (!m[2]) begin
                    chk(array_col, c);
                end
            end else begin
                chk(array_rd, 1'b0);
            end
            j = k - 2;
            c = col_of(s, 3'(j), ilv);
            chk(dq_oe, j >= 0 && j < (ch ? 4 : 8));
            chk(dqs_oe, j >= 0 && j < (ch ? 4 : 8));
            if (j >= 0 && j < (ch ? 4 : 8)) begin
                chk(dqs_out, !j[0]);
                chk(dq_out, !m[2] ? {5'h14, c} : m[1:0] == SRC_PATTERN ? (j[0] ? PATTERN_ODD : PATTERN_EVEN)
                    : m[1:0] == SRC_THERMAL ? THERM : RESERVED_DATA);
            end
        end
    endtask
    task automatic run_write(input logic [14:0] a, input logic ch, input int p);
        int j;
        sbo_ctrl_model_inst.issue(CMD_WRITE, 3'h0, a);
        fork
            sbo_ctrl_model_inst.write_data(8'h30);
            for (int k = 1; k <= 10; k++) begin
                @(posedge clk);
                #1;
                j = k - 1;
                chk(int_write_start, k == p);
                if (j >= 0 && j < (ch ? 4 : 8)) begin
                    chk(wr_en, 1'b1);
                    chk(wr_col, (ch ? {a[2], 2'h0} : 3'h0) + 3'(j));
                    chk(wr_data, 8'h30 + 8'(j));
                end else begin
                    chk(wr_en, 1'b0);
                end
            end
        join
    endtask
    task automatic t_orders;
        for (int ilv = 0; ilv < 2; ilv++) begin
            sbo_ctrl_model_inst.set_mode(BANK_MODE_ZERO, {ilv[0], 1'b0, BL_BURST_OF_EIGHT});
            for (int s = 0; s < 8; s++) begin
                run_read(3'(s), ilv[0], 1'b0, 3'h0, 1'b1);
            end
        end
    endtask
    task automatic t_chop_read;
        sbo_ctrl_model_inst.set_mode(BANK_MODE_ZERO, {2'h2, BL_FIXED_CHOP_FOUR});
        run_read(3'h5, 1'b1, 1'b1, 3'h0, 1'b1);
        sbo_ctrl_model_inst.set_mode(BANK_MODE_ZERO, {2'h0, BL_ON_THE_FLY});
        run_read(3'h6, 1'b0, 1'b1, 3'h0, 1'b0);
        run_read(3'h3, 1'b0, 1'b0, 3'h0, 1'b1);
    endtask
    task automatic t_readout;
        sbo_ctrl_model_inst.set_mode(BANK_MODE_ZERO, {2'h0, BL_BURST_OF_EIGHT});
        for (int src = 0; src < 4; src++) begin
            sbo_ctrl_model_inst.set_mode(BANK_MODE_THREE, {2'h1, src[1:0]});
            #1;
            chk(readout_active, 1'b1);
            chk(readout_source, src[1:0]);
            run_read(3'h2, 1'b0, 1'b0, {1'b1, src[1:0]}, 1'b1);
        end
        sbo_ctrl_model_inst.set_mode(BANK_MODE_THREE, {2'h0, SRC_THERMAL});
        #1;
        chk(readout_source, 2'h0);
        run_read(3'h1, 1'b0, 1'b0, 3'h0, 1'b1);
    endtask
    task automatic t_write;
        run_write(15'h1007, 1'b0, 8);
        sbo_ctrl_model_inst.set_mode(BANK_MODE_ZERO, {2'h0, BL_FIXED_CHOP_FOUR});
        run_write(15'h0006, 1'b1, 6);
        sbo_ctrl_model_inst.set_mode(BANK_MODE_ZERO, {2'h0, BL_ON_THE_FLY});
        run_write(15'h0003, 1'b1, 8);
        run_write(15'h1005, 1'b0, 8);
    endtask
    // Reset in mid-run must clear register three and leave the block ready at once
    task automatic t_reset;
        sbo_ctrl_model_inst.set_mode(BANK_MODE_THREE, {2'h1, SRC_THERMAL});
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(readout_active, 1'b0);
        chk(readout_source, 2'h0);
        chk(dq_oe, 1'b0);
        run_read(3'h4, 1'b0, 1'b0, 3'h0, 1'b1);
    endtask
    initial begin
        repeat (7) @(posedge clk);
        #1;
        chk(readout_active, 1'b0);
        chk(dq_oe, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        t_orders();
        t_chop_read();
        t_readout();
        t_write();
        t_reset();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
